// ---- design/sar_adc_regs.vh ----
// Register offsets, field positions, reset values and timing counts.
// Assumes inclusion by the converter control files only.
`ifndef SAR_ADC_REGS_VH
`define SAR_ADC_REGS_VH
`define CTRL_ONE_ADDR 12'h034
`define CTRL_TWO_ADDR 12'h035
`define RES_LOW_ADDR 12'h036
`define RES_HIGH_ADDR 12'h037
`define BYTE_ADDR(i) ((i) * 4)
`define START_BIT 7
`define MODE_HI 6
`define MODE_LO 5
`define AEN_BIT 4
`define CHAN_HI 3
`define CHAN_LO 0
`define DONE_BIT 7
`define BUSY_BIT 6
`define TIME_HI 2
`define TIME_LO 0
`define RESET_BYTE 8'h00
`define MODE_OFF 2'h0
`define MODE_SINGLE 2'h1
`define MODE_REPEAT 2'h3
`define CHAN_MAX 4'h4
`define CYC_T0 10'h027
`define CYC_T1 10'h04e
`define CYC_T2 10'h09c
`define CYC_T3 10'h138
`define CYC_T4 10'h270
`define LAT_T0 8'h0a
`define LAT_T1 8'h20
`define LAT_T2 8'h80
`endif

// ---- design/cycle_counter.v ----
// Down counter that loads a count and pulses when it reaches one.
// Assumes pclk and presetn of the converter control unit.
module cycle_counter #(
  parameter W = 10
) (
  input wire pclk,
  input wire presetn,
  input wire load,
  input wire clear,
  input wire [W-1:0] count,
  output reg running,
  output wire expire
);
  reg [W-1:0] cnt_reg;
  assign expire = running && (cnt_reg == {{(W-1){1'b0}}, 1'b1});
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= {W{1'b0}};
      running <= 1'b0;
    end else if (clear) begin
      cnt_reg <= {W{1'b0}};
      running <= 1'b0;
    end else if (load) begin
      cnt_reg <= count;
      running <= 1'b1;
    end else if (running) begin
      cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
      if (expire) begin
        running <= 1'b0;
      end
    end
  end
endmodule // cycle_counter

// ---- design/sar_adc_control_unit.v ----
// Control and status logic of a 10-bit successive-approximation converter.
// Assumes an APB master on pclk and an analog core that returns a
// 10-bit code in step with the conversion timer; low_power_entry is a
// pulse from the same clock domain.
`include "sar_adc_regs.vh"

module sar_adc_control_unit (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [13:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire low_power_entry,
  input wire [9:0] sample_code,
  output wire [3:0] channel_select,
  output wire [4:0] analog_input_en,
  output wire reference_current,
  output wire sample_strobe,
  output reg conversion_done_irq
);
  localparam ST_IDLE = 2'h0;
  localparam ST_LEAD = 2'h1;
  localparam ST_CONV = 2'h2;
  localparam ST_STORE = 2'h3;

  reg [1:0] state_reg;
  reg start_reg;
  reg [1:0] operating_mode_field;
  reg analog_enable;
  reg [3:0] chan_reg;
  reg [2:0] time_reg;
  reg done_reg;
  reg busy_reg;
  reg [7:0] low_reg;
  reg [1:0] high_reg;
  reg low_read_reg;
  reg [9:0] code_reg;
  reg [9:0] conv_len;
  reg [7:0] lat_len;
  wire access;
  wire wr;
  wire rd;
  wire [11:0] waddr;
  wire aligned;
  wire hit_one;
  wire hit_two;
  wire hit_low;
  wire hit_high;
  wire mode_off_wr;
  wire start_req;
  wire time_ok;
  wire mode_ok;
  wire lat_load;
  wire lat_done;
  wire conv_load;
  wire conv_done;
  wire abort;
  wire lead_run;
  wire conv_run;

  assign access = psel && penable;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;
  assign pready = 1'b1;
  assign waddr = paddr[13:2];
  assign aligned = (paddr[1:0] == 2'b00);
  assign hit_one = aligned && (waddr == `CTRL_ONE_ADDR);
  assign hit_two = aligned && (waddr == `CTRL_TWO_ADDR);
  assign hit_low = aligned && (waddr == `RES_LOW_ADDR);
  assign hit_high = aligned && (waddr == `RES_HIGH_ADDR);
  assign pslverr = access && !(hit_one || hit_two || hit_low || hit_high);

  assign mode_off_wr = wr && hit_one &&
    (pwdata[`MODE_HI:`MODE_LO] == `MODE_OFF);
  assign abort = low_power_entry || mode_off_wr;
  // Reserved time or mode codes start nothing
  assign time_ok = (time_reg <= 3'h4);
  assign mode_ok = (pwdata[`MODE_HI:`MODE_LO] == `MODE_SINGLE) ||
    (pwdata[`MODE_HI:`MODE_LO] == `MODE_REPEAT);
  assign start_req = wr && hit_one && pwdata[`START_BIT] && mode_ok &&
    time_ok && !abort && (state_reg == ST_IDLE);

  always @* begin
    case (time_reg)
      3'h0: conv_len = `CYC_T0;
      3'h1: conv_len = `CYC_T1;
      3'h2: conv_len = `CYC_T2;
      3'h3: conv_len = `CYC_T3;
      default: conv_len = `CYC_T4;
    endcase
    case (time_reg[2:1])
      2'h0: lat_len = `LAT_T0;
      2'h1: lat_len = `LAT_T1;
      default: lat_len = `LAT_T2;
    endcase
  end

  // Start latency: half the overhead before conversion; storing takes one cycle, the other half is never counted
  assign lat_load = start_req ||
    (state_reg == ST_STORE && operating_mode_field == `MODE_REPEAT &&
     !abort);
  cycle_counter #(.W(8)) lead_timer (
    .pclk(pclk),
    .presetn(presetn),
    .load(lat_load),
    .clear(abort),
    .count({1'b0, lat_len[7:1]}),
    .running(lead_run),
    .expire(lat_done)
  );
  assign conv_load = (state_reg == ST_LEAD) && lat_done && !abort;
  cycle_counter #(.W(10)) conv_timer (
    .pclk(pclk),
    .presetn(presetn),
    .load(conv_load),
    .clear(abort),
    .count(conv_len),
    .running(conv_run),
    .expire(conv_done)
  );

  assign reference_current = conv_run;
  assign sample_strobe = conv_done;
  assign channel_select = chan_reg;
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_ain
      localparam [3:0] chan_code = gi;
      assign analog_input_en[gi] = analog_enable &&
        (chan_reg == chan_code);
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      code_reg <= 10'h000;
    end else if (abort) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start_req) begin
            state_reg <= ST_LEAD;
          end
        end
        ST_LEAD: begin
          if (lat_done) begin
            state_reg <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (conv_done) begin
            code_reg <= sample_code;
            state_reg <= ST_STORE;
          end
        end
        ST_STORE: begin
          if (operating_mode_field == `MODE_REPEAT) begin
            state_reg <= ST_LEAD;
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_reg <= 1'b0;
      operating_mode_field <= `MODE_OFF;
      analog_enable <= 1'b0;
      chan_reg <= 4'h0;
      time_reg <= 3'h0;
    end else if (low_power_entry) begin
      start_reg <= 1'b0;
      operating_mode_field <= `MODE_OFF;
      analog_enable <= 1'b0;
    end else begin
      if (start_reg) begin
        start_reg <= 1'b0;
      end
      if (wr && hit_one) begin
        start_reg <= start_req;
        operating_mode_field <= pwdata[`MODE_HI:`MODE_LO];
        analog_enable <= pwdata[`AEN_BIT];
        chan_reg <= pwdata[`CHAN_HI:`CHAN_LO];
      end
      if (wr && hit_two) begin
        time_reg <= pwdata[`TIME_HI:`TIME_LO];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg <= 1'b0;
      busy_reg <= 1'b0;
      low_reg <= `RESET_BYTE;
      high_reg <= 2'h0;
      low_read_reg <= 1'b0;
      conversion_done_irq <= 1'b0;
    end else if (abort) begin
      done_reg <= 1'b0;
      busy_reg <= 1'b0;
      low_reg <= `RESET_BYTE;
      high_reg <= 2'h0;
      low_read_reg <= 1'b0;
      conversion_done_irq <= 1'b0;
    end else begin
      conversion_done_irq <= 1'b0;
      if (rd && hit_low) begin
        low_read_reg <= 1'b1;
      end
      if (rd && hit_high) begin
        low_read_reg <= 1'b0;
        done_reg <= 1'b0;
      end
      if (start_req) begin
        busy_reg <= 1'b1;
        done_reg <= 1'b0;
      end
      if (state_reg == ST_STORE) begin
        if (operating_mode_field != `MODE_REPEAT) begin
          busy_reg <= 1'b0;
        end
        // Completion between low and high reads is dropped; set wins
        if (!low_read_reg) begin
          low_reg <= code_reg[7:0];
          high_reg <= code_reg[9:8];
          done_reg <= 1'b1;
          conversion_done_irq <= 1'b1;
        end
      end
    end
  end
  // the guard above keeps old result and raises no done flag or interrupt

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr[1:0] != 2'b00) begin
        prdata <= 32'h00000000;
      end else if (waddr == `CTRL_ONE_ADDR) begin
        prdata <= {24'h000000, 1'b0, operating_mode_field,
          analog_enable, chan_reg};
      end else if (waddr == `CTRL_TWO_ADDR) begin
        prdata <= {24'h000000, done_reg, busy_reg, 3'h0,
          time_reg};
      end else if (waddr == `RES_LOW_ADDR) begin
        prdata <= {24'h000000, low_reg};
      end else if (waddr == `RES_HIGH_ADDR) begin
        prdata <= {24'h000000, 6'h00, high_reg};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end
endmodule // sar_adc_control_unit

// ---- test/analog_core_model.sv ----
// Behavioural analog core facing the converter control unit.
// Assumes the bench supplies the level to convert on pclk.
module analog_core_model (
  input wire pclk,
  input wire reference_current,
  input wire [9:0] level,
  output logic [9:0] sample_code = 10'h000
);
  timeunit 1ns;
  timeprecision 1ns;
  // Code is only valid while the reference runs; otherwise it toggles
  always @(posedge pclk) begin
    sample_code <= reference_current ? level : ~sample_code;
  end
endmodule // analog_core_model

// ---- test/sar_adc_control_unit_sva.sv ----
// Port checker for the converter control unit.
// Assumes binding into sar_adc_control_unit, one clock domain.
module ctl_sva (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [13:0] paddr,
  input wire [31:0] pwdata,
  input wire pslverr,
  input wire low_power_entry,
  input wire [3:0] channel_select,
  input wire [4:0] analog_input_en,
  input wire reference_current,
  input wire sample_strobe,
  input wire conversion_done_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire off_wr = acc && pwrite && paddr == 14'h0d0 && pwdata[6:5] == 2'b00;
  a_map_err: assert property (acc |-> pslverr ==
    !(paddr inside {14'h0d0, 14'h0d4, 14'h0d8, 14'h0dc}))
    else $error("bad slave error");
  a_irq_pulse: assert property (conversion_done_irq |=>
    !conversion_done_irq) else $error("irq too long");
  a_irq_store: assert property (conversion_done_irq |->
    $past(sample_strobe) || $past(sample_strobe, 2))
    else $error("irq without sample");
  a_strobe_ref: assert property (sample_strobe |->
    reference_current) else $error("sample with reference off");
  a_lp_abort: assert property (low_power_entry |=>
    !reference_current && analog_input_en == 5'h00)
    else $error("low power did not abort");
  a_lp_noirq: assert property (low_power_entry |=>
    !conversion_done_irq [*2]) else $error("irq after low power");
  a_off_stops: assert property (off_wr |=> !reference_current)
    else $error("mode off did not stop");
  a_chan_gate: assert property (analog_input_en != 5'h00 |->
    analog_input_en == 5'h01 << channel_select)
    else $error("wrong channel enabled");
endmodule // ctl_sva
bind sar_adc_control_unit ctl_sva ctl_sva_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
  .low_power_entry(low_power_entry), .channel_select(channel_select),
  .analog_input_en(analog_input_en), .sample_strobe(sample_strobe),
  .reference_current(reference_current),
  .conversion_done_irq(conversion_done_irq));

// ---- test/sar_adc_control_unit_bench.sv ----
// Self-checking bench for the converter control unit over APB.
// Assumes the analog core model on the far side of the block.
module sar_adc_control_unit_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [13:0] ctl1 = 14'h0d0, ctl2 = 14'h0d4;
  localparam logic [13:0] rlo = 14'h0d8, rhi = 14'h0dc;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, low_power_entry = 1'b0;
  logic [13:0] paddr = 14'h0;
  logic [31:0] pwdata = 32'h0, lfsr = 32'h145cf8f8;
  logic [9:0] level = 10'h0, sample_code;
  logic [7:0] expq[$];
  wire [31:0] prdata;
  wire pready, pslverr, ref_on, strobe, irq;
  wire [3:0] chan;
  wire [4:0] ain_en;
  int fail_count = 0, n_tests = 0, clk_n = 0;
  int cyc[5] = '{39, 78, 156, 312, 624};
  int lat[5] = '{10, 10, 32, 32, 128};
  sar_adc_control_unit sar_adc_control_unit_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .low_power_entry(low_power_entry),
    .sample_code(sample_code), .channel_select(chan),
    .analog_input_en(ain_en), .reference_current(ref_on),
    .sample_strobe(strobe), .conversion_done_irq(irq));
  analog_core_model analog_core_model_i (.pclk(pclk),
    .reference_current(ref_on), .level(level), .sample_code(sample_code));
  initial forever #10 pclk = ~pclk;
  always @(posedge pclk) clk_n <= clk_n + 1;
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic end_sim;
    if (fail_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready)
      chk(prdata, {24'h0, expq.pop_front()});
    if (psel && penable && pready)
      chk(pslverr, paddr[13:4] != 10'h00d);
  end
  task automatic apb(input logic w, input logic [13:0] a,
                     input logic [7:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) fail_count++;
    if (k >= 50) end_sim();
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [13:0] a, input logic [7:0] e);
    expq.push_back(e);
    apb(1'b0, a, 8'h00);
  endtask
  task automatic wt(input logic s);
    int k;
    k = 0;
    do begin
      @(negedge pclk);
      k++;
    end while ((s ? strobe : irq) !== 1'b1 && k < 2000);
    if (k >= 2000) fail_count++;
    if (k >= 2000) end_sim();
  endtask
  initial begin
    int s;
    logic [9:0] old;
    logic [3:0] ch;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (cyc[i]) rd(ctl1 + 14'(i * 4), 8'h00);
    rd(14'h0e0, 8'h00);
    wr(ctl2, 8'hf0);
    rd(ctl2, 8'h00);
    for (int i = 0; i < 5; i++) begin
      lfsr = nxt(lfsr);
      ch = lfsr[3:0] % 4'h5;
      level <= lfsr[17:8];
      wr(ctl2, 8'(i));
      wr(ctl1, {4'h3, ch});
      @(negedge pclk);
      chk(ain_en, 5'h01 << ch);
      chk(chan, ch);
      wr(ctl1, {4'hb, ch});
      s = clk_n;
      rd(ctl1, {4'h3, ch});
      rd(ctl2, 8'h40 | 8'(i));
      wt(1'b0);
      chk(clk_n - s >= cyc[i] && clk_n - s <= cyc[i] + lat[i] + 3, 1);
      rd(ctl2, 8'h80 | 8'(i));
      rd(rlo, lfsr[15:8]);
      rd(rhi, {6'h0, lfsr[17:16]});
      rd(ctl2, 8'(i));
    end
    wr(ctl2, 8'h00);
    wr(ctl1, {4'hb, ch});
    wt(1'b0);
    wr(ctl1, {4'hb, ch});
    rd(ctl2, 8'h40);
    wt(1'b0);
    old = level;
    wr(ctl1, {4'hf, ch});
    wt(1'b0);
    rd(rlo, old[7:0]);
    level <= ~old;
    wt(1'b1);
    wt(1'b1);
    rd(rhi, {6'h0, old[9:8]});
    rd(ctl2, 8'h40);
    wt(1'b0);
    rd(rhi, {6'h0, ~old[9:8]});
    wr(ctl1, {4'h1, ch});
    rd(ctl2, 8'h00);
    rd(rlo, 8'h00);
    wr(ctl1, {4'hd, ch});
    rd(ctl2, 8'h00);
    wr(ctl2, 8'h05);
    wr(ctl1, {4'hb, ch});
    rd(ctl2, 8'h05);
    wr(ctl2, 8'h00);
    wr(ctl1, {4'hb, ch});
    low_power_entry <= 1'b1;
    @(posedge pclk);
    low_power_entry <= 1'b0;
    rd(ctl1, {4'h0, ch});
    rd(ctl2, 8'h00);
    end_sim();
  end
endmodule // sar_adc_control_unit_bench
